// File: design/dual_timer_counter_params.svh
// register offsets, field positions, reset values and timing counts of the dual timer/counter
`ifndef DUAL_TIMER_COUNTER_PARAMS_SVH
`define DUAL_TIMER_COUNTER_PARAMS_SVH

`define TIMER_CONTROL_ADDR 8'h88
`define TIMER_MODE_SELECT_ADDR 8'h89
`define TIMER0_COUNT_LOW_ADDR 8'h8A
`define TIMER1_COUNT_LOW_ADDR 8'h8B
`define TIMER0_COUNT_HIGH_ADDR 8'h8C
`define TIMER1_COUNT_HIGH_ADDR 8'h8D

// timer_control fields
`define TIMER1_OVERFLOW_FLAG_BIT 7
`define TIMER1_RUN_BIT 6
`define TIMER0_OVERFLOW_FLAG_BIT 5
`define TIMER0_RUN_BIT 4

// timer_mode_select fields, timer 1 in the upper nibble
`define TIMER1_CFG_LSB 4
`define TIMER0_CFG_LSB 0
`define CFG_GATE_BIT 3
`define CFG_SELECT_BIT 2
`define CFG_MODE_LSB 0

`define COUNT_RESET 8'h00
`define MODE_SELECT_RESET 8'h00
`define CONTROL_RESET 1'b0
`define READ_UNMAPPED 8'h00

// one machine cycle in mpu clock periods
`define MACHINE_CYCLE_CLOCKS 12
`define MC_COUNT_LAST 4'hB
`define MC_COUNT_RESET 4'h0

// 13-bit mode keeps the top low-byte bits at zero
`define LOW13_MASK 8'h1F
`define BYTE_ALL_ONES 8'hFF

`endif

// File: design/dual_timer_counter_pkg.sv
// types shared by the dual timer/counter
package dual_timer_counter_pkg;

   typedef enum logic [1:0] {
      MODE_13BIT = 2'b00,
      MODE_16BIT = 2'b01,
      MODE_RELOAD = 2'b10,
      MODE_SPLIT = 2'b11
   } timer_mode_type;

   typedef struct packed {
      logic gate;
      logic select_counter;
      timer_mode_type mode;
   } timer_cfg_type;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } sfr_req_type;

   typedef struct packed {
      logic overflow;
      logic [7:0] high;
      logic [7:0] low;
   } count_step_type;

endpackage

// File: design/dual_timer_counter.sv
// two 16-bit timer/counters reached through special function registers
`timescale 1ns/1ps
`include "dual_timer_counter_params.svh"

// What this block does
// - two independent timers 0 and 1 each hold a 16-bit count that software sets up as timer or counter.
// - in timer operation the count advances once per machine cycle of 12 mpu clock periods.
// - in counter operation the count advances on a high-to-low transition of that timer's count input.
// - detecting a falling edge on a count input takes two machine cycles.
// - each timer counts while its run bit in timer_control is one and stops when it is cleared.
// - each timer has a 2-bit mode field: 00 13-bit, 01 16-bit, 10 8-bit auto-reload, 11 split/stop.
// - mode 00 counts 13 bits, 5 in the low byte and 8 in the high byte, the top 3 low bits reading zero.
// - mode 10 increments only the low byte and reloads it from the high byte on overflow.
// - timer 1 in mode 11 stops and holds its value.
// - timer 0 in mode 11 splits into two independent 8-bit counters.
// - an overflow sets the timer's flag, cleared by software or by interrupt service.
// - with the gate bit set the timer advances only while run is set and counts falling input edges.
// - a select bit per timer chooses counter operation when one and, with the gate bit clear, timer operation when zero.
module dual_timer_counter (
   input wire logic clock,                                   // mpu clock
   input wire logic resetn,                                  // asynchronous reset, active low
   input wire dual_timer_counter_pkg::sfr_req_type sfr_req,  // register address, strobes, write data
   output logic [7:0] sfr_rdata,                             // read data, one cycle after rd
   input wire logic timer0_count_input,                      // external count input of timer 0
   input wire logic timer1_count_input,                      // external count input of timer 1
   input wire logic timer0_irq_ack,                          // interrupt service of timer 0, clears its flag
   input wire logic timer1_irq_ack,                          // interrupt service of timer 1, clears its flag
   output logic timer0_overflow_flag,                        // timer 0 overflow flag
   output logic timer1_overflow_flag                         // timer 1 overflow flag
);

   // one step of a count byte pair; split mode acts as a plain 8-bit low counter
   function automatic dual_timer_counter_pkg::count_step_type count_step(
      input dual_timer_counter_pkg::timer_mode_type mode,
      input logic [7:0] high,
      input logic [7:0] low,
      input logic inc
   );
      dual_timer_counter_pkg::count_step_type res;
      logic [12:0] v13;
      logic [15:0] v16;
      res.overflow = 1'b0;
      res.high = high;
      res.low = low;
      v13 = {high, low[4:0]} + 13'h0001;
      v16 = {high, low} + 16'h0001;
      if (inc) begin
         case (mode)
            dual_timer_counter_pkg::MODE_13BIT: begin
               res.overflow = ({high, low[4:0]} == 13'h1FFF);
               res.high = v13[12:5];
               res.low = {3'h0, v13[4:0]};
            end
            dual_timer_counter_pkg::MODE_16BIT: begin
               res.overflow = ({high, low} == 16'hFFFF);
               res.high = v16[15:8];
               res.low = v16[7:0];
            end
            dual_timer_counter_pkg::MODE_RELOAD: begin
               res.overflow = (low == `BYTE_ALL_ONES);
               res.low = res.overflow ? high : low + 8'h01;
            end
            dual_timer_counter_pkg::MODE_SPLIT: begin
               res.overflow = (low == `BYTE_ALL_ONES);
               res.low = low + 8'h01;
            end
            default: begin
               res.overflow = 1'b0;
            end
         endcase
      end
      return res;
   endfunction

   logic [7:0] count_low_r [0:1];
   logic [7:0] count_high_r [0:1];
   logic [7:0] mode_select_r;
   logic [1:0] run_r;
   logic [1:0] flag_r;
   logic [3:0] mc_count_r;
   logic [1:0] pin_sample_r;
   logic [1:0] pin_prev_r;
   logic [7:0] rdata_r;

   dual_timer_counter_pkg::timer_cfg_type cfg [0:1];
   dual_timer_counter_pkg::count_step_type step [0:1];
   dual_timer_counter_pkg::count_step_type step_split_high;
   wire logic mc_tick;
   wire logic [1:0] pins;
   wire logic [1:0] fall;
   wire logic [1:0] edge_mode;
   wire logic [1:0] inc;
   wire logic split0;
   wire logic [1:0] hw_set;
   wire logic [1:0] ack;
   wire logic wr_control;
   wire logic wr_mode;
   wire logic [1:0] wr_low;
   wire logic [1:0] wr_high;
   logic [7:0] rd_mux;

   assign cfg[0] = mode_select_r[`TIMER0_CFG_LSB +: 4];
   assign cfg[1] = mode_select_r[`TIMER1_CFG_LSB +: 4];
   assign pins = {timer1_count_input, timer0_count_input};
   assign ack = {timer1_irq_ack, timer0_irq_ack};
   assign split0 = (cfg[0].mode == dual_timer_counter_pkg::MODE_SPLIT);

   // machine cycle enable from the 12-period divider
   assign mc_tick = (mc_count_r == `MC_COUNT_LAST);

   // the pins are sampled once per machine cycle, so a level must hold that long to be seen
   // an edge is a one sample followed by a zero sample: two machine cycles to recognise
   assign fall = {2{mc_tick}} & pin_prev_r & ~pin_sample_r;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_timer
         assign edge_mode[g] = cfg[g].select_counter | cfg[g].gate;
         assign inc[g] = run_r[g] & (edge_mode[g] ? fall[g] : mc_tick)
            & ~(g == 1 && cfg[1].mode == dual_timer_counter_pkg::MODE_SPLIT);
         assign step[g] = count_step(cfg[g].mode, count_high_r[g], count_low_r[g], inc[g]);
      end
   endgenerate

   // split timer 0 high byte runs on timer 1 run bit at the machine rate
   assign step_split_high = count_step(dual_timer_counter_pkg::MODE_SPLIT, 8'h00, count_high_r[0],
      split0 & run_r[1] & mc_tick);

   // while timer 0 is split, timer 1 keeps counting but its flag belongs to the timer 0 high byte
   assign hw_set[0] = step[0].overflow;
   assign hw_set[1] = split0 ? step_split_high.overflow : step[1].overflow;

   assign wr_control = sfr_req.wr && sfr_req.addr == `TIMER_CONTROL_ADDR;
   assign wr_mode = sfr_req.wr && sfr_req.addr == `TIMER_MODE_SELECT_ADDR;
   assign wr_low[0] = sfr_req.wr && sfr_req.addr == `TIMER0_COUNT_LOW_ADDR;
   assign wr_low[1] = sfr_req.wr && sfr_req.addr == `TIMER1_COUNT_LOW_ADDR;
   assign wr_high[0] = sfr_req.wr && sfr_req.addr == `TIMER0_COUNT_HIGH_ADDR;
   assign wr_high[1] = sfr_req.wr && sfr_req.addr == `TIMER1_COUNT_HIGH_ADDR;

   // in 13-bit mode the top low-byte bits read zero whatever software wrote there
   always_comb begin
      case (sfr_req.addr)
         `TIMER_CONTROL_ADDR: rd_mux = {flag_r[1], run_r[1], flag_r[0], run_r[0], 4'h0};
         `TIMER_MODE_SELECT_ADDR: rd_mux = mode_select_r;
         `TIMER0_COUNT_LOW_ADDR: rd_mux = (cfg[0].mode == dual_timer_counter_pkg::MODE_13BIT)
            ? (count_low_r[0] & `LOW13_MASK) : count_low_r[0];
         `TIMER1_COUNT_LOW_ADDR: rd_mux = (cfg[1].mode == dual_timer_counter_pkg::MODE_13BIT)
            ? (count_low_r[1] & `LOW13_MASK) : count_low_r[1];
         `TIMER0_COUNT_HIGH_ADDR: rd_mux = count_high_r[0];
         `TIMER1_COUNT_HIGH_ADDR: rd_mux = count_high_r[1];
         default: rd_mux = `READ_UNMAPPED;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mc_count_r <= `MC_COUNT_RESET;
      end else begin
         mc_count_r <= mc_tick ? `MC_COUNT_RESET : mc_count_r + 4'h1;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pin_sample_r <= 2'h0;
         pin_prev_r <= 2'h0;
      end else if (mc_tick) begin
         pin_sample_r <= pins;
         pin_prev_r <= pin_sample_r;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mode_select_r <= `MODE_SELECT_RESET;
         run_r <= {2{`CONTROL_RESET}};
         rdata_r <= `READ_UNMAPPED;
      end else begin
         if (wr_mode) begin
            mode_select_r <= sfr_req.wdata;
         end
         if (wr_control) begin
            run_r <= {sfr_req.wdata[`TIMER1_RUN_BIT], sfr_req.wdata[`TIMER0_RUN_BIT]};
         end
         if (sfr_req.rd) begin
            rdata_r <= rd_mux;
         end
      end
   end

   // a hardware overflow wins over a software clear or an interrupt acknowledge in the same cycle
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         flag_r <= {2{`CONTROL_RESET}};
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (hw_set[i]) begin
               flag_r[i] <= 1'b1;
            end else if (ack[i]) begin
               flag_r[i] <= 1'b0;
            end else if (wr_control) begin
               flag_r[i] <= (i == 0) ? sfr_req.wdata[`TIMER0_OVERFLOW_FLAG_BIT]
                  : sfr_req.wdata[`TIMER1_OVERFLOW_FLAG_BIT];
            end
         end
      end
   end

   // a software write to a count byte replaces the count step of that cycle
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 2; i++) begin
            count_low_r[i] <= `COUNT_RESET;
            count_high_r[i] <= `COUNT_RESET;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            count_low_r[i] <= wr_low[i] ? sfr_req.wdata : step[i].low;
         end
         if (wr_high[0]) begin
            count_high_r[0] <= sfr_req.wdata;
         end else if (split0) begin
            count_high_r[0] <= step_split_high.low;
         end else begin
            count_high_r[0] <= step[0].high;
         end
         count_high_r[1] <= wr_high[1] ? sfr_req.wdata : step[1].high;
      end
   end

   assign sfr_rdata = rdata_r;
   assign timer0_overflow_flag = flag_r[0];
   assign timer1_overflow_flag = flag_r[1];

endmodule

// File: bench/dual_timer_counter_chk.sv
// port-level assertions of the dual timer/counter
`timescale 1ns/1ps
module dual_timer_counter_chk (
   input wire logic clock, // mpu clock
   input wire logic resetn, // reset, active low
   input wire dual_timer_counter_pkg::sfr_req_type sfr_req, // register request
   input wire logic [7:0] sfr_rdata, // read data
   input wire logic timer0_irq_ack, // flag 0 service
   input wire logic timer1_irq_ack, // flag 1 service
   input wire logic timer0_overflow_flag, // flag 0
   input wire logic timer1_overflow_flag // flag 1
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   logic [7:0] mode_r;
   logic [1:0] run_r;
   wire ctl_wr = sfr_req.wr && sfr_req.addr == 8'h88;
   wire mode_wr = sfr_req.wr && sfr_req.addr == 8'h89;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mode_r <= 8'h00;
         run_r <= 2'h0;
      end else begin
         if (mode_wr) mode_r <= sfr_req.wdata;
         if (ctl_wr) run_r <= {sfr_req.wdata[6], sfr_req.wdata[4]};
      end
   end
   sequence rd_at(logic [7:0] a);
      sfr_req.rd && sfr_req.addr == a;
   endsequence
   a_ctl_low_zero: assert property (rd_at(8'h88) |=> sfr_rdata[3:0] == 4'h0)
      else $error("control low bits not zero");
   a_flag_mirror: assert property (rd_at(8'h88) |=> sfr_rdata[7] == $past(timer1_overflow_flag)
      && sfr_rdata[5] == $past(timer0_overflow_flag)) else $error("flag bits differ from flag ports");
   a_rdata_holds: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
      else $error("read data moved without a read");
   a_mode0_top_zero: assert property (rd_at(8'h8A) ##0 mode_r[1:0] == 2'b00 |=> sfr_rdata[7:5] == 3'h0)
      else $error("13-bit low byte top bits not zero");
   a_flag0_needs_run: assert property ($rose(timer0_overflow_flag)
      |-> $past(run_r[0] || ctl_wr && sfr_req.wdata[5])) else $error("flag 0 set while stopped");
   a_flag1_needs_run: assert property ($rose(timer1_overflow_flag)
      |-> $past(run_r[1] || ctl_wr && sfr_req.wdata[7])) else $error("flag 1 set while stopped");
   a_mode3_holds: assert property ($rose(timer1_overflow_flag) |-> $past(mode_r[5:4] != 2'b11
      || mode_r[1:0] == 2'b11 || ctl_wr && sfr_req.wdata[7])) else $error("held timer 1 overflowed");
   a_flag0_clear_cause: assert property ($fell(timer0_overflow_flag)
      |-> $past(timer0_irq_ack || ctl_wr && !sfr_req.wdata[5])) else $error("flag 0 cleared alone");
   a_flag1_clear_cause: assert property ($fell(timer1_overflow_flag)
      |-> $past(timer1_irq_ack || ctl_wr && !sfr_req.wdata[7])) else $error("flag 1 cleared alone");
endmodule

// File: bench/count_source.sv
// count input source that keeps each level for at least one machine cycle
`timescale 1ns/1ps
module count_source (
   input wire logic clock, // mpu clock
   input wire logic enable, // make pulses
   input wire logic [7:0] half, // clocks per level, 12 or more
   output logic level, // count input pin
   output int falls // falling edges made so far
);
   int n = 0;
   initial level = 1'b1;
   initial falls = 0;
   // a stopped source holds its level, as a real pin would
   always @(negedge clock) begin
      n = enable ? n + 1 : 0;
      if (n >= int'(half)) begin
         n = 0;
         falls = falls + int'(level);
         level = !level;
      end
   end
endmodule

// File: bench/test_dual_timer_counter.sv
// self-checking bench of the dual timer/counter
`timescale 1ns/1ps
module test_dual_timer_counter;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   dual_timer_counter_pkg::sfr_req_type sfr_req = '0;
   logic [7:0] sfr_rdata, v;
   logic [1:0] ack = 2'h0;
   logic [1:0] src_en = 2'h0;
   logic [7:0] half = 8'h0C;
   logic [1:0] pin, flag;
   int f0, f1;
   int errors = 0;
   int comparisons = 0;
   always #12.5 clock = !clock;
   dual_timer_counter u_dut (.clock(clock), .resetn(resetn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
      .timer0_count_input(pin[0]), .timer1_count_input(pin[1]), .timer0_irq_ack(ack[0]),
      .timer1_irq_ack(ack[1]), .timer0_overflow_flag(flag[0]), .timer1_overflow_flag(flag[1]));
   count_source u_src0 (.clock(clock), .enable(src_en[0]), .half(half), .level(pin[0]), .falls(f0));
   count_source u_src1 (.clock(clock), .enable(src_en[1]), .half(half), .level(pin[1]), .falls(f1));
   task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one access per call; the strobe drops on the taking edge so calls can follow back to back
   task automatic sfr(logic [7:0] a, logic w, logic [7:0] d);
      sfr_req = '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge clock);
      sfr_req <= '0;
      @(negedge clock);
   endtask
   task automatic rd(logic [7:0] a, output logic [7:0] r);
      sfr(a, 1'b0, 8'h00);
      r = sfr_rdata;
   endtask
   function automatic logic [17:0] model(logic [1:0] m, logic sp, logic [7:0] h, logic [7:0] l, int k);
      logic a = 1'b0;
      logic b = 1'b0;
      logic [12:0] c;
      for (int i = 0; i < k; i++) begin
         if (sp) begin
            b |= h == 8'hFF;
            h++;
            a |= l == 8'hFF;
            l++;
         end else if (m == 2'b00) begin
            c = {h, l[4:0]} + 13'h0001;
            a |= c == 13'h0000;
            {h, l} = {c[12:5], 3'h0, c[4:0]};
         end else if (m == 2'b01) begin
            a |= {h, l} == 16'hFFFF;
            {h, l} = {h, l} + 16'h0001;
         end else if (m == 2'b10) begin
            a |= l == 8'hFF;
            l = (l == 8'hFF) ? h : l + 8'h01;
         end
      end
      return {b, a, h, l};
   endfunction
   task automatic timed_case(logic t, logic [1:0] m, logic [7:0] h, logic [7:0] l, int k);
      logic [17:0] e;
      logic [7:0] vl, vh;
      logic [1:0] fb;
      logic sp;
      sp = !t && m == 2'b11;
      e = model(m, sp, h, l, k);
      sfr(8'h88, 1'b1, 8'h00);
      sfr(8'h89, 1'b1, t ? {2'b00, m, 4'h0} : {6'h00, m});
      sfr(8'h8A + t, 1'b1, l);
      sfr(8'h8C + t, 1'b1, h);
      sfr(8'h88, 1'b1, sp ? 8'h50 : (t ? 8'h40 : 8'h10));
      // exactly k ticks fall between the start and stop edges
      repeat (12 * k - 1) @(negedge clock);
      fb = flag;
      sfr(8'h88, 1'b1, 8'h00);
      rd(8'h8A + t, vl);
      rd(8'h8C + t, vh);
      e[17:16] = sp ? e[17:16] : (t ? {e[16], 1'b0} : {1'b0, e[16]});
      check("timed count", {fb | flag, vh, vl}, e);
   endtask
   task automatic counted_case(logic t, logic [3:0] cfg, int d);
      int s;
      logic [7:0] vl, vh;
      sfr(8'h88, 1'b1, 8'h00);
      sfr(8'h89, 1'b1, t ? {cfg, 4'h0} : {4'h0, cfg});
      sfr(8'h8A + t, 1'b1, 8'h00);
      sfr(8'h8C + t, 1'b1, 8'h00);
      sfr(8'h88, 1'b1, t ? 8'h40 : 8'h10);
      s = t ? f1 : f0;
      src_en[t] <= 1'b1;
      repeat (d) @(negedge clock);
      src_en[t] <= 1'b0;
      repeat (36) @(negedge clock);
      sfr(8'h88, 1'b1, 8'h00);
      rd(8'h8A + t, vl);
      rd(8'h8C + t, vh);
      check("events", {2'b00, vh, vl}, 18'((t ? f1 : f0) - s));
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(83));
      repeat (12) @(negedge clock);
      resetn = 1'b1;
      sfr(8'h8E, 1'b1, 8'hFF);
      for (int a = 8'h88; a < 8'h8F; a++) begin
         rd(8'(a), v);
         check("reset value", {10'h000, v}, 18'h00000);
      end
      timed_case(1'b0, 2'b01, 8'hFF, 8'hF0, 20);
      timed_case(1'b1, 2'b00, 8'hFF, 8'hFE, 3);
      timed_case(1'b0, 2'b10, 8'hF0, 8'hFE, 4);
      timed_case(1'b1, 2'b11, 8'h12, 8'h34, 5);
      timed_case(1'b0, 2'b11, 8'hFE, 8'hFD, 4);
      repeat (12) timed_case(1'($urandom), 2'($urandom), 8'($urandom), 8'($urandom), 1 + $urandom % 30);
      for (int i = 0; i < 4; i++) begin
         half = 8'(12 + $urandom % 9);
         counted_case(i[0], i[1] ? 4'h9 : 4'h5, 200 + $urandom % 200);
      end
      sfr(8'h88, 1'b1, 8'hA0);
      check("flags set", {16'h0000, flag}, 18'h00003);
      ack = 2'b11;
      @(negedge clock);
      ack = 2'b00;
      check("flags serviced", {16'h0000, flag}, 18'h00000);
      report_and_stop();
   end
endmodule
bind dual_timer_counter dual_timer_counter_chk u_chk (.clock(clock), .resetn(resetn), .sfr_req(sfr_req),
   .sfr_rdata(sfr_rdata), .timer0_irq_ack(timer0_irq_ack), .timer1_irq_ack(timer1_irq_ack),
   .timer0_overflow_flag(timer0_overflow_flag), .timer1_overflow_flag(timer1_overflow_flag));
